// [logic/adcseq_sequencer.sv]
// Functional notes
// - Bits 7:5 equal 001 write averaging register.
// - Averaging off gives one conversion per result.
// - Average count select gives 4/8/16/32.
// - Repeat scan returns 4/8/12/16 results.
// - Bits 7:4 equal 0001 write reset register.
// - Reset bit 3 zero all, one FIFO.
// - Mode 00 start pulse runs full scan.
// - Flag low only with scan in FIFO.
// - Flag held until select or start falls.
// - Temperature result precedes channel results.
// - Mode 01 falling edge wakes and tracks.
// - Temperature in mode 01 timed internally.
// - Mode 01 rising edge converts, then flag.
// - Mode 01 averaging stores then advances channel.
// - Mode 01 temperature on first rising edge.
// - Mode 10 default; byte write starts scan.
// - Mode 10 flag released only by select.
// - Reset gives zero registers, mode 10, shutdown.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module adcseq_sequencer import adcseq_pkg::*; #(
	parameter int NUM_CH     = 16,
	parameter int FIFO_DEPTH = 16,
	parameter int SAMPLE_W   = 10,
	parameter int RESULT_W   = 12,
	parameter int ACC_W      = 15
) (
	input  wire logic                i_clk,
	input  wire logic                i_resetn,
	input  wire logic [ADDR_W-1:0]   i_reg_addr,
	input  wire logic [7:0]          i_reg_wdata,
	input  wire logic                i_reg_wr,
	input  wire logic                i_reg_rd,
	output logic      [RDATA_W-1:0]  o_reg_rdata,
	input  wire logic                i_convert_start_n,
	input  wire logic                i_chip_select_n,
	input  wire logic [SAMPLE_W-1:0] i_adc_sample,
	input  wire logic [RESULT_W-1:0] i_temp_sample,
	output logic                     o_end_of_conversion_n,
	output logic      [3:0]          o_mux_channel,
	output logic                     o_converter_awake,
	output logic                     o_temp_measure
);

	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

	// ==========================================================
	// Pin synchronisation and edges
	logic [1:0] pins_sync;
	logic       convert_start_n_now;
	logic       cs_now;
	logic       convert_start_n_prev;
	logic       cs_prev;
	logic       convert_start_n_fall;
	logic       convert_start_n_rise;
	logic       cs_fall;

	adcseq_sync #(
		.WIDTH     (2),
		.RESET_VAL (2'h3)
	) u_sync (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_async  ({i_convert_start_n, i_chip_select_n}),
		.o_sync   (pins_sync)
	);

	assign convert_start_n_now = pins_sync[1];
	assign cs_now    = pins_sync[0];

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			convert_start_n_prev <= 1'b1;
			cs_prev    <= 1'b1;
		end else begin
			convert_start_n_prev <= convert_start_n_now;
			cs_prev    <= cs_now;
		end
	end

	assign convert_start_n_fall = convert_start_n_prev && !convert_start_n_now;
	assign convert_start_n_rise = !convert_start_n_prev && convert_start_n_now;
	assign cs_fall    = cs_prev && !cs_now;

	// ==========================================================
	// Control byte decode
	logic ctrl_wr;
	logic is_conv;
	logic is_avg;
	logic is_rst;
	logic full_reset;
	logic fifo_clear;

	assign ctrl_wr = i_reg_wr && (i_reg_addr == ADDR_CTRL);
	assign is_conv = ctrl_wr && i_reg_wdata[CONV_SEL_BIT];
	assign is_avg  = ctrl_wr
		&& (i_reg_wdata[BYTE_MSB:AVG_CODE_LO] == AVG_CODE);
	assign is_rst  = ctrl_wr
		&& (i_reg_wdata[BYTE_MSB:RST_CODE_LO] == RST_CODE);
	assign full_reset = is_rst && !i_reg_wdata[RST_FIFO_BIT];
	assign fifo_clear = is_rst;

	// ==========================================================
	// Configuration registers
	logic           avg_on;
	logic [1:0]     avg_sel;
	logic [1:0]     rep_sel;
	adcseq_ckmode_t clock_mode;
	logic [3:0]     conv_ch;
	adcseq_scan_t   conv_scan;
	logic           conv_temp;
	logic           serial_go;

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			avg_on  <= 1'b0;
			avg_sel <= 2'h0;
			rep_sel <= 2'h0;
		end else if (full_reset) begin
			avg_on  <= 1'b0;
			avg_sel <= 2'h0;
			rep_sel <= 2'h0;
		end else if (is_avg) begin
			avg_on  <= i_reg_wdata[AVG_ON_BIT];
			avg_sel <= i_reg_wdata[AVG_SEL_HI:AVG_SEL_LO];
			rep_sel <= i_reg_wdata[REP_HI:REP_LO];
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			clock_mode <= CKM_SERIAL_SCAN;
		end else if (full_reset) begin
			clock_mode <= CKM_SERIAL_SCAN;
		end else if (i_reg_wr && i_reg_addr == ADDR_SEQCFG) begin
			clock_mode <= adcseq_ckmode_t'(i_reg_wdata[CKM_HI:CKM_LO]);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			conv_ch   <= 4'h0;
			conv_scan <= SCAN_UP_TO_N;
			conv_temp <= 1'b0;
		end else if (full_reset) begin
			conv_ch   <= 4'h0;
			conv_scan <= SCAN_UP_TO_N;
			conv_temp <= 1'b0;
		end else if (is_conv) begin
			conv_ch   <= i_reg_wdata[CH_HI:CH_LO];
			conv_scan <= adcseq_scan_t'(i_reg_wdata[SCAN_HI:SCAN_LO]);
			conv_temp <= i_reg_wdata[TEMP_BIT];
		end
	end

	// Byte is latched first, scan starts one cycle later
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			serial_go <= 1'b0;
		end else begin
			serial_go <= is_conv && !full_reset
				&& (clock_mode == CKM_SERIAL_SCAN);
		end
	end

	// ==========================================================
	// Derived sequence values
	logic [2:0]  avg_shift;
	logic [5:0]  conv_last;
	logic [3:0]  first_ch;
	logic [3:0]  last_ch;
	logic [3:0]  rep_last;
	logic [3:0]  cur_ch;
	logic [3:0]  rep_idx;
	logic [4:0]  conv_cnt;
	logic        scan_last;
	logic        mode01;
	logic        scan_go;

	assign avg_shift = avg_on ? AVG_BASE_SHIFT + {1'b0, avg_sel}
		: 3'h0;
	assign conv_last = 6'((7'h01 << avg_shift) - 7'h01);
	assign first_ch  = (conv_scan == SCAN_UP_TO_N) ? 4'h0 : conv_ch;
	assign last_ch   = (conv_scan == SCAN_N_UP) ? 4'(NUM_CH - 1) : conv_ch;
	assign rep_last  = {rep_sel, 2'h0} + REP_UNIT_M1;
	assign mode01    = (clock_mode == CKM_CONVERT_START_N_SINGLE);
	assign scan_go   = serial_go
		|| (clock_mode == CKM_CONVERT_START_N_SCAN && convert_start_n_rise);

	always_comb begin
		unique case (conv_scan)
			SCAN_REPEAT_N: scan_last = (rep_idx == rep_last);
			SCAN_ONLY_N:   scan_last = 1'b1;
			default:       scan_last = (cur_ch == last_ch);
		endcase
	end

	// ==========================================================
	// Sequencer state machine
	adcseq_state_t state;
	adcseq_state_t next_state;
	logic [TMR_W-1:0] tmr;
	logic [TMR_W-1:0] tmr_lim;
	logic             tmr_done;
	logic             temp_pend;
	logic             conv_full;

	always_comb begin
		unique case (state)
			S_WAKE:  tmr_lim = TMR_W'(WAKE_CYC - 1);
			S_TEMP:  tmr_lim = TMR_W'(TEMP_CYC - 1);
			S_ACQ:   tmr_lim = TMR_W'(ACQ_CYC - 1);
			S_CONV:  tmr_lim = TMR_W'(CONV_CYC - 1);
			default: tmr_lim = '0;
		endcase
	end

	assign tmr_done  = (tmr == tmr_lim);
	assign conv_full = ({1'b0, conv_cnt} == conv_last);

	always_comb begin
		next_state = state;
		unique case (state)
			S_IDLE: begin
				if (mode01 && convert_start_n_fall) begin
					next_state = S_TRACK;
				end else if (scan_go) begin
					next_state = S_WAKE;
				end
			end
			S_WAKE: begin
				if (tmr_done) begin
					next_state = temp_pend ? S_TEMP : S_ACQ;
				end
			end
			S_TEMP: begin
				if (tmr_done) begin
					next_state = mode01 ? S_IDLE : S_ACQ;
				end
			end
			S_ACQ: begin
				if (tmr_done) begin
					next_state = S_CONV;
				end
			end
			S_TRACK: begin
				if (convert_start_n_rise) begin
					next_state = temp_pend ? S_TEMP : S_CONV;
				end
			end
			S_CONV: begin
				if (tmr_done) begin
					if (conv_full) begin
						next_state = S_STORE;
					end else begin
						next_state = mode01 ? S_IDLE : S_ACQ;
					end
				end
			end
			S_STORE: begin
				next_state = (mode01 || scan_last) ? S_IDLE : S_ACQ;
			end
		endcase
		if (full_reset) begin
			next_state = S_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state <= S_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Timer restarts on every state change
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tmr <= '0;
		end else if (next_state != state) begin
			tmr <= '0;
		end else if (!tmr_done) begin
			tmr <= tmr + 1'b1;
		end
	end

	// ==========================================================
	// Channel walk and accumulation
	logic [ACC_W-1:0] acc;
	logic             seq_load;

	assign seq_load = (state == S_IDLE && next_state == S_WAKE)
		|| (is_conv && mode01);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			cur_ch    <= 4'h0;
			rep_idx   <= 4'h0;
			conv_cnt  <= 5'h00;
			acc       <= '0;
			temp_pend <= 1'b0;
		end else if (full_reset) begin
			cur_ch    <= 4'h0;
			rep_idx   <= 4'h0;
			conv_cnt  <= 5'h00;
			acc       <= '0;
			temp_pend <= 1'b0;
		end else if (seq_load) begin
			cur_ch    <= is_conv
				? ((i_reg_wdata[SCAN_HI:SCAN_LO] == SCAN_UP_TO_N)
				? 4'h0 : i_reg_wdata[CH_HI:CH_LO]) : first_ch;
			rep_idx   <= 4'h0;
			conv_cnt  <= 5'h00;
			acc       <= '0;
			temp_pend <= is_conv ? i_reg_wdata[TEMP_BIT] : conv_temp;
		end else begin
			if (state == S_TEMP && tmr_done) begin
				temp_pend <= 1'b0;
			end
			if (state == S_CONV && tmr_done) begin
				acc      <= acc + ACC_W'(i_adc_sample);
				conv_cnt <= conv_full ? 5'h00 : conv_cnt + 1'b1;
			end
			if (state == S_STORE) begin
				acc <= '0;
				if (scan_last) begin
					cur_ch  <= first_ch;
					rep_idx <= 4'h0;
				end else if (conv_scan == SCAN_REPEAT_N) begin
					rep_idx <= rep_idx + 1'b1;
				end else begin
					cur_ch <= cur_ch + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Result FIFO
	logic                fifo_push;
	logic [RESULT_W-1:0] fifo_wdata;
	logic                fifo_pop;
	logic [RESULT_W-1:0] fifo_head;
	logic [CNT_W-1:0]    fifo_count;
	logic                fifo_empty;

	assign fifo_push  = (state == S_STORE)
		|| (state == S_TEMP && tmr_done);
	assign fifo_wdata = (state == S_TEMP) ? i_temp_sample
		: RESULT_W'(acc >> avg_shift);
	assign fifo_pop   = i_reg_rd && (i_reg_addr == ADDR_RESULT);

	adcseq_fifo #(
		.WIDTH (RESULT_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clk    (i_clk),
		.i_resetn (i_resetn),
		.i_clear  (fifo_clear),
		.i_push   (fifo_push),
		.i_data   (fifo_wdata),
		.i_pop    (fifo_pop),
		.o_head   (fifo_head),
		.o_count  (fifo_count),
		.o_full   (),
		.o_empty  (fifo_empty)
	);

	// ==========================================================
	// End-of-conversion flag
	logic seq_done;
	logic eoc_release;

	// Any return to idle other than by a full reset marks a finished scan or conversion
	assign seq_done    = (state != S_IDLE) && (next_state == S_IDLE)
		&& !full_reset;
	assign eoc_release = cs_fall || (convert_start_n_fall
		&& clock_mode != CKM_SERIAL_SCAN);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_end_of_conversion_n <= 1'b1;
		end else if (seq_done) begin
			o_end_of_conversion_n <= 1'b0;
		end else if (full_reset || eoc_release) begin
			o_end_of_conversion_n <= 1'b1;
		end
	end

	// ==========================================================
	// Converter controls
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_converter_awake <= 1'b0;
			o_temp_measure    <= 1'b0;
		end else begin
			o_converter_awake <= (next_state != S_IDLE);
			o_temp_measure    <= (next_state == S_TEMP);
		end
	end

	assign o_mux_channel = cur_ch;

	// ==========================================================
	// Register read port
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_reg_rdata <= '0;
		end else if (i_reg_rd) begin
			unique case (i_reg_addr)
				ADDR_SEQCFG: o_reg_rdata <= RDATA_W'(clock_mode);
				ADDR_STATUS: begin
					o_reg_rdata <= '0;
					o_reg_rdata[STAT_EOC_BIT]  <= o_end_of_conversion_n;
					o_reg_rdata[STAT_BUSY_BIT] <= (state != S_IDLE);
					o_reg_rdata[STAT_BUSY_BIT+1 +: CNT_W] <= fifo_count;
				end
				ADDR_RESULT: o_reg_rdata <= fifo_empty ? '0
					: RDATA_W'(fifo_head);
				default:     o_reg_rdata <= '0;
			endcase
		end else begin
			o_reg_rdata <= '0;
		end
	end

endmodule
`default_nettype wire

// [inc/adcseq_pkg.sv]
`default_nettype none
package adcseq_pkg;

	// ==========================================================
	// Timing
	localparam int CLK_MHZ     = 10;
	localparam int T_WAKE_NS   = 65000;
	localparam int T_ACQ_NS    = 1400;
	localparam int T_CONV_NS   = 3000;
	localparam int T_TEMP_NS   = 80000;
	localparam int WAKE_CYC    = (T_WAKE_NS * CLK_MHZ + 999) / 1000;
	localparam int ACQ_CYC     = (T_ACQ_NS * CLK_MHZ + 999) / 1000;
	localparam int CONV_CYC    = (T_CONV_NS * CLK_MHZ + 999) / 1000;
	localparam int TEMP_CYC    = (T_TEMP_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W       = 10;

	// ==========================================================
	// Register port map
	localparam int ADDR_W      = 4;
	localparam int RDATA_W     = 16;
	localparam logic [3:0] ADDR_CTRL   = 4'h0;
	localparam logic [3:0] ADDR_SEQCFG = 4'h1;
	localparam logic [3:0] ADDR_STATUS = 4'h2;
	localparam logic [3:0] ADDR_RESULT = 4'h3;

	// ==========================================================
	// Control byte layout
	localparam int BYTE_MSB     = 7;
	localparam int CONV_SEL_BIT = 7;
	localparam int AVG_CODE_LO  = 5;
	localparam logic [2:0] AVG_CODE = 3'h1;
	localparam int RST_CODE_LO  = 4;
	localparam logic [3:0] RST_CODE = 4'h1;
	localparam int AVG_ON_BIT   = 4;
	localparam int AVG_SEL_HI   = 3;
	localparam int AVG_SEL_LO   = 2;
	localparam int REP_HI       = 1;
	localparam int REP_LO       = 0;
	localparam int RST_FIFO_BIT = 3;
	localparam int CH_HI        = 6;
	localparam int CH_LO        = 3;
	localparam int SCAN_HI      = 2;
	localparam int SCAN_LO      = 1;
	localparam int TEMP_BIT     = 0;
	localparam int CKM_HI       = 1;
	localparam int CKM_LO       = 0;
	localparam logic [2:0] AVG_BASE_SHIFT = 3'h2;
	localparam logic [3:0] REP_UNIT_M1    = 4'h3;

	// ==========================================================
	// Status word
	localparam int STAT_EOC_BIT  = 0;
	localparam int STAT_BUSY_BIT = 1;

	typedef enum logic [1:0] {
		CKM_CONVERT_START_N_SCAN   = 2'h0,
		CKM_CONVERT_START_N_SINGLE = 2'h1,
		CKM_SERIAL_SCAN  = 2'h2,
		CKM_EXTERNAL     = 2'h3
	} adcseq_ckmode_t;

	typedef enum logic [1:0] {
		SCAN_UP_TO_N  = 2'h0,
		SCAN_N_UP     = 2'h1,
		SCAN_REPEAT_N = 2'h2,
		SCAN_ONLY_N   = 2'h3
	} adcseq_scan_t;

	typedef enum logic [6:0] {
		S_IDLE  = 7'h01,
		S_WAKE  = 7'h02,
		S_TEMP  = 7'h04,
		S_ACQ   = 7'h08,
		S_TRACK = 7'h10,
		S_CONV  = 7'h20,
		S_STORE = 7'h40
	} adcseq_state_t;

endpackage
`default_nettype wire

// [logic/adcseq_sync.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-stage synchroniser for pin levels
module adcseq_sync #(
	parameter int               WIDTH     = 2,
	parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] stage1;

	// First stage is read only by the second
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			stage1 <= RESET_VAL;
			o_sync <= RESET_VAL;
		end else begin
			stage1 <= i_async;
			o_sync <= stage1;
		end
	end

endmodule
`default_nettype wire

// [logic/adcseq_fifo.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Result FIFO, flip-flop storage
module adcseq_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16,
	parameter int PTR_W = $clog2(DEPTH),
	parameter int CNT_W = $clog2(DEPTH + 1)
) (
	input  wire logic             i_clk,
	input  wire logic             i_resetn,
	input  wire logic             i_clear,
	input  wire logic             i_push,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_pop,
	output logic      [WIDTH-1:0] o_head,
	output logic      [CNT_W-1:0] o_count,
	output logic                  o_full,
	output logic                  o_empty
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr;
	logic [PTR_W-1:0] rd_ptr;
	logic             do_push;
	logic             do_pop;

	// Pushes into a full FIFO are dropped
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;
	assign o_full  = (o_count == CNT_W'(DEPTH));
	assign o_empty = (o_count == '0);
	assign o_head  = mem[rd_ptr];

	always_ff @(posedge i_clk) begin
		if (do_push) begin
			mem[wr_ptr] <= i_data;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			o_count <= '0;
		end else if (i_clear) begin
			wr_ptr  <= '0;
			rd_ptr  <= '0;
			o_count <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (do_pop) begin
				rd_ptr <= (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
			if (do_push && !do_pop) begin
				o_count <= o_count + 1'b1;
			end else if (do_pop && !do_push) begin
				o_count <= o_count - 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// [testbench/adcseq_sequencer_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module adcseq_seq_chk import adcseq_pkg::*; (
	input wire logic               i_clk,
	input wire logic               i_resetn,
	input wire logic [ADDR_W-1:0]  i_reg_addr,
	input wire logic [7:0]         i_reg_wdata,
	input wire logic               i_reg_wr,
	input wire logic               i_reg_rd,
	input wire logic [RDATA_W-1:0] o_reg_rdata,
	input wire logic               i_convert_start_n,
	input wire logic               i_chip_select_n,
	input wire logic               o_end_of_conversion_n,
	input wire logic               o_converter_awake,
	input wire logic               o_temp_measure
);
	// ==========================================================
	// Pin and write history
	logic [5:0] s_hist;
	logic [5:0] c_hist;
	logic [5:0] w_hist;
	logic [9:0] temp_cyc;
	logic       ctl_wr;
	assign ctl_wr = i_reg_wr && i_reg_addr == ADDR_CTRL;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			s_hist   <= '1;
			c_hist   <= '1;
			w_hist   <= '0;
			temp_cyc <= '0;
		end else begin
			s_hist   <= {s_hist[4:0], i_convert_start_n};
			c_hist   <= {c_hist[4:0], i_chip_select_n};
			w_hist   <= {w_hist[4:0], ctl_wr && i_reg_wdata[7]};
			temp_cyc <= o_temp_measure ? temp_cyc + 10'h1 : 10'h0;
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	// ==========================================================
	// Properties
	chk_reset_quiet: assert property ($rose(i_resetn) |->
		o_end_of_conversion_n && !o_converter_awake && !o_temp_measure)
		else $error("outputs active after reset");
	chk_full_reset: assert property (
		$past(ctl_wr && i_reg_wdata[7:3] == 5'h02)
		|-> o_end_of_conversion_n && !o_converter_awake)
		else $error("full soft reset left sequence running");
	chk_fifo_clear: assert property (
		$past(ctl_wr && i_reg_wdata[7:3] == 5'h03, 2) && i_reg_rd
		&& i_reg_addr == ADDR_STATUS |=> o_reg_rdata[6:2] == 5'h00)
		else $error("fifo not empty after clear");
	chk_cs_release: assert property (
		$fell(i_chip_select_n) && !o_end_of_conversion_n
		&& !o_converter_awake ##1 !i_chip_select_n [*3]
		|-> ##[0:2] o_end_of_conversion_n)
		else $error("done flag not released by select");
	chk_flag_holds: assert property ($rose(o_end_of_conversion_n) |->
		|(s_hist[5:1] & ~s_hist[4:0]) || |(c_hist[5:1] & ~c_hist[4:0])
		|| $past(ctl_wr && i_reg_wdata[7:3] == 5'h02))
		else $error("done flag released without cause");
	chk_done_asleep: assert property (
		$fell(o_end_of_conversion_n) |-> ##[0:1] !o_converter_awake)
		else $error("done flag while converter awake");
	chk_wake_cause: assert property ($rose(o_converter_awake) |->
		|w_hist[5:1] || |(s_hist[5:1] ^ s_hist[4:0]))
		else $error("converter woke without request");
	chk_temp_len: assert property ($fell(o_temp_measure) |->
		temp_cyc >= 10'(TEMP_CYC - 1) && temp_cyc <= 10'(TEMP_CYC + 1))
		else $error("temperature timing wrong length");
endmodule
bind adcseq_sequencer adcseq_seq_chk u_chk (.i_clk, .i_resetn,
	.i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
	.i_convert_start_n, .i_chip_select_n, .o_end_of_conversion_n,
	.o_converter_awake, .o_temp_measure);
`default_nettype wire

// [testbench/adcseq_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module adcseq_host_model (
	input  wire logic i_clk,
	input  wire logic i_eoc_n,
	output logic      o_convert_start_n,
	output logic      o_chip_select_n
);
	// Half of the 800 ns link period
	localparam time HALF = 400;
	bit pending = 1'b0;
	initial begin
		o_convert_start_n = 1'b1;
		o_chip_select_n   = 1'b1;
	end
	always @(negedge i_eoc_n) pending = 1'b0;
	// ==========================================================
	// Start pulse, low for a number of half link periods
	task automatic start_pulse(input int halves);
		int w;
		w = 0;
		while (pending && w < 20000) begin
			@(posedge i_clk);
			w++;
		end
		#37 o_convert_start_n = 1'b0;
		#(HALF * halves) o_convert_start_n = 1'b1;
		pending = 1'b1;
	endtask
	// Select only once the flag is down
	task automatic cs_pulse();
		int w;
		w = 0;
		while (i_eoc_n && w < 20000) begin
			@(posedge i_clk);
			w++;
		end
		#37 o_chip_select_n = 1'b0;
		#(HALF) o_chip_select_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// [testbench/adcseq_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
module adcseq_sequencer_test;
	import adcseq_pkg::*;
	logic               clk    = 1'b0;
	logic               resetn = 1'b0;
	logic [ADDR_W-1:0]  addr   = '0;
	logic [7:0]         wdata  = '0;
	logic               wr     = 1'b0;
	logic               rd     = 1'b0;
	logic [9:0]         adc    = '0;
	logic [11:0]        tsmp   = '0;
	logic [RDATA_W-1:0] rdata;
	logic [3:0]         mux;
	logic               start_n;
	logic               cs_n;
	logic               eoc_n;
	logic               awake;
	logic               temp;
	logic [15:0]        d;
	int                 err_count = 0;
	int                 n_checks  = 0;
	int                 exp_q[$];

	always #50 clk = ~clk;

	adcseq_sequencer DUT (.i_clk(clk), .i_resetn(resetn),
		.i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_wr(wr),
		.i_reg_rd(rd), .o_reg_rdata(rdata),
		.i_convert_start_n(start_n), .i_chip_select_n(cs_n),
		.i_adc_sample(adc), .i_temp_sample(tsmp),
		.o_end_of_conversion_n(eoc_n), .o_mux_channel(mux),
		.o_converter_awake(awake), .o_temp_measure(temp));
	adcseq_host_model host (.i_clk(clk), .i_eoc_n(eoc_n),
		.o_convert_start_n(start_n), .o_chip_select_n(cs_n));

	// ==========================================================
	// Bus and check tasks
	task automatic check(input string what, input logic [15:0] seen,
		input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr  <= a;
		wdata <= v;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	task automatic new_samples();
		@(posedge clk);
		adc  <= 10'($urandom_range(1023, 0));
		tsmp <= 12'($urandom_range(4095, 0));
	endtask
	// Averaging a constant sample must give it back unchanged
	task automatic expect_n(input int n, input bit t);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back((i == 0 && t) ? int'(tsmp) : int'(adc));
		end
	endtask
	task automatic wait_eoc(input int lim);
		int w;
		w = 0;
		while (eoc_n !== 1'b0 && w < lim) begin
			@(negedge clk);
			w++;
		end
		check("eoc_n low", 16'(eoc_n), 16'h0);
	endtask
	task automatic finish_scan(input int n, input int lim, input bit dr);
		wait_eoc(lim);
		rd_reg(ADDR_STATUS, d);
		check("fifo count", 16'(d[6:2]), 16'(n));
		host.cs_pulse();
		repeat (2) @(negedge clk);
		check("eoc_n released", 16'(eoc_n), 16'h1);
		repeat (dr ? n : 0) begin
			rd_reg(ADDR_RESULT, d);
			check("result", d, 16'(exp_q.pop_front()));
		end
	endtask
	task automatic scan10(input logic [7:0] cb, input int n, input int lim,
		input bit dr);
		new_samples();
		wr_reg(ADDR_CTRL, cb);
		expect_n(n, cb[0]);
		finish_scan(n, lim, dr);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		#4_000_000;
		err_count++;
		print_verdict();
	end

	// ==========================================================
	// Tests
	initial begin
		void'($urandom(41));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd_reg(ADDR_STATUS, d);
		check("status", d, 16'h0001);
		rd_reg(ADDR_SEQCFG, d);
		check("clock mode", d, 16'h0002);
		rd_reg(4'h9, d);
		check("unmapped", d, 16'h0000);
		$display("test reset done");
		scan10(8'haf, 2, 1600, 1'b1);
		for (int r = 0; r < 4; r++) begin
			wr_reg(ADDR_CTRL, 8'h20 | 8'(r));
			scan10(8'h94, 4 * (r + 1), 700 + 50 * (r + 1) * 4, 1'b1);
		end
		for (int s = 0; s < 4; s++) begin
			wr_reg(ADDR_CTRL, 8'h30 | 8'(s << 2));
			scan10(8'h94, 4, 700 + 4 * (45 << (s + 2)), 1'b1);
		end
		$display("test scan modes done");
		wr_reg(ADDR_CTRL, 8'h20);
		new_samples();
		wr_reg(ADDR_CTRL, 8'h98);
		expect_n(4, 1'b0);
		wait_eoc(900);
		// Start pin must not release the flag in serial mode
		host.start_pulse(1);
		repeat (2) @(negedge clk);
		check("eoc_n held", 16'(eoc_n), 16'h0);
		finish_scan(4, 10, 1'b1);
		scan10(8'h94, 4, 900, 1'b0);
		wr_reg(ADDR_CTRL, 8'h1f);
		exp_q.delete();
		rd_reg(ADDR_STATUS, d);
		check("status cleared", d, 16'h0001);
		rd_reg(ADDR_RESULT, d);
		check("empty result", d, 16'h0000);
		wr_reg(ADDR_SEQCFG, 8'h01);
		wr_reg(ADDR_CTRL, 8'h3f);
		wr_reg(ADDR_CTRL, 8'h10);
		rd_reg(ADDR_SEQCFG, d);
		check("mode after reset", d, 16'h0002);
		scan10(8'h9e, 1, 760, 1'b1);
		$display("test soft reset done");
		wr_reg(ADDR_SEQCFG, 8'h00);
		wr_reg(ADDR_CTRL, 8'h9e);
		new_samples();
		host.start_pulse(1);
		wait_eoc(800);
		host.start_pulse(1);
		check("eoc_n start release", 16'(eoc_n), 16'h1);
		expect_n(2, 1'b0);
		finish_scan(2, 800, 1'b1);
		wr_reg(ADDR_SEQCFG, 8'h01);
		wr_reg(ADDR_CTRL, 8'h30);
		wr_reg(ADDR_CTRL, 8'hf3);
		new_samples();
		// First pulse runs the temperature alone, then four averaged
		for (int p = 0; p < 5; p++) begin
			host.start_pulse(5);
			wait_eoc(p == 0 ? 900 : 100);
			rd_reg(ADDR_STATUS, d);
			check("avg pulses", 16'(d[6:2]), 16'(1 + p / 4));
			check("mux channel", 16'(mux), 16'(p < 4 ? 14 : 15));
		end
		expect_n(2, 1'b1);
		finish_scan(2, 10, 1'b1);
		$display("test start pin modes done");
		print_verdict();
	end
endmodule
`default_nettype wire
